// *** hw/jtg_tap.v ***
// Boundary-scan test access port with TAP controller, instruction and data registers.
`timescale 1ns/1ps
`include "jtg_defines.vh"
module jtg_tap #(
    parameter                  N_IN    = 16,
    parameter                  N_OUT   = 16,
    // The identification value is arbitrary; bit 0 must stay one.
    parameter [31:0]           ID_CODE = 32'h1234_5001
) (
    input  wire                ref_clk,
    input  wire                rstn,
    input  wire                tck,
    input  wire                tms,
    input  wire                tdi,
    input  wire                test_reset_n,
    output reg                 tdo,
    output reg                 tdo_oe,
    input  wire [N_IN-1:0]     pin_in,
    input  wire [N_OUT-1:0]    core_out,
    output reg  [N_OUT-1:0]    pin_out,
    output reg                 cell_shift_clock,
    output wire [`JTG_IR_LEN-1:0] instr_out
);

    localparam BSR_LEN = N_IN + N_OUT;

    localparam [3:0] ST_TLR    = 4'h0;
    localparam [3:0] ST_RTI    = 4'h1;
    localparam [3:0] ST_SEL_DR = 4'h2;
    localparam [3:0] ST_CAP_DR = 4'h3;
    localparam [3:0] ST_SH_DR  = 4'h4;
    localparam [3:0] ST_EX1_DR = 4'h5;
    localparam [3:0] ST_PA_DR  = 4'h6;
    localparam [3:0] ST_EX2_DR = 4'h7;
    localparam [3:0] ST_UP_DR  = 4'h8;
    localparam [3:0] ST_SEL_IR = 4'h9;
    localparam [3:0] ST_CAP_IR = 4'hA;
    localparam [3:0] ST_SH_IR  = 4'hB;
    localparam [3:0] ST_EX1_IR = 4'hC;
    localparam [3:0] ST_PA_IR  = 4'hD;
    localparam [3:0] ST_EX2_IR = 4'hE;
    localparam [3:0] ST_UP_IR  = 4'hF;

    // Unknown opcodes fall back to the bypass path.
    function [1:0] sel_of;
        input [`JTG_IR_LEN-1:0] op;
        begin
            case (op)
                `JTG_OP_EXTEST:       sel_of = `JTG_SEL_BSR;
                `JTG_OP_SAMPLE:       sel_of = `JTG_SEL_BSR;
                `JTG_OP_SINGLE_CHAIN: sel_of = `JTG_SEL_BSR;
                `JTG_OP_IDCODE:       sel_of = `JTG_SEL_ID;
                default:              sel_of = `JTG_SEL_BYPASS;
            endcase
        end
    endfunction

    // States in which the serial output is driven.
    function shift_state;
        input [3:0] st;
        begin
            case (st)
                ST_SH_DR: shift_state = 1'b1;
                ST_SH_IR: shift_state = 1'b1;
                default:  shift_state = 1'b0;
            endcase
        end
    endfunction

    // States in which the chain cells see the test clock.
    function cell_clock_state;
        input [3:0] st;
        begin
            case (st)
                ST_CAP_DR: cell_clock_state = 1'b1;
                ST_SH_DR:  cell_clock_state = 1'b1;
                default:   cell_clock_state = 1'b0;
            endcase
        end
    endfunction

    // Test reset asserts the controller reset at once and releases it on the clock.
    wire                       tap_arst_n = rstn & test_reset_n;
    reg  [1:0]                 rst_sync;
    wire                       tap_rst_n  = rst_sync[1];

    always @(posedge ref_clk or negedge tap_arst_n) begin
        if (!tap_arst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    reg                        tck_s1;
    reg                        tck_s2;
    reg                        tck_s3;
    reg                        tms_s1;
    reg                        tms_s2;
    reg                        tdi_s1;
    reg                        tdi_s2;
    reg  [N_IN-1:0]            pin_s1;
    reg  [N_IN-1:0]            pin_s2;

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tck_s1 <= 1'b0;
            tck_s2 <= 1'b0;
            tck_s3 <= 1'b0;
            tms_s1 <= 1'b1;
            tms_s2 <= 1'b1;
            tdi_s1 <= 1'b1;
            tdi_s2 <= 1'b1;
        end else begin
            tck_s1 <= tck;
            tck_s2 <= tck_s1;
            tck_s3 <= tck_s2;
            tms_s1 <= tms;
            tms_s2 <= tms_s1;
            tdi_s1 <= tdi;
            tdi_s2 <= tdi_s1;
        end
    end

    // Observed pins get their own synchroniser pair.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1 <= {N_IN{1'b0}};
            pin_s2 <= {N_IN{1'b0}};
        end else begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
        end
    end

    wire                       tck_rise = tck_s2 & ~tck_s3;
    wire                       tck_fall = ~tck_s2 & tck_s3;

    reg  [3:0]                 state;
    reg  [3:0]                 next_state;

    always @* begin
        case (state)
            ST_TLR:    next_state = tms_s2 ? ST_TLR    : ST_RTI;
            ST_RTI:    next_state = tms_s2 ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: next_state = tms_s2 ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms_s2 ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  next_state = tms_s2 ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = tms_s2 ? ST_UP_DR  : ST_PA_DR;
            ST_PA_DR:  next_state = tms_s2 ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: next_state = tms_s2 ? ST_UP_DR  : ST_SH_DR;
            ST_UP_DR:  next_state = tms_s2 ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: next_state = tms_s2 ? ST_TLR    : ST_CAP_IR;
            ST_CAP_IR: next_state = tms_s2 ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  next_state = tms_s2 ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = tms_s2 ? ST_UP_IR  : ST_PA_IR;
            ST_PA_IR:  next_state = tms_s2 ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: next_state = tms_s2 ? ST_UP_IR  : ST_SH_IR;
            ST_UP_IR:  next_state = tms_s2 ? ST_SEL_DR : ST_RTI;
            default:   next_state = ST_TLR;
        endcase
    end

    always @(posedge ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            state <= ST_TLR;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    reg  [`JTG_IR_LEN-1:0]     ir_shift;
    reg  [`JTG_IR_LEN-1:0]     instr;
    reg                        bypass_reg;
    reg  [`JTG_ID_LEN-1:0]     id_reg;
    reg  [BSR_LEN-1:0]         bsr;
    reg  [N_OUT-1:0]           upd_out;
    wire [1:0]                 sel = sel_of(instr);
    wire [BSR_LEN-1:0]         smp = {pin_out, pin_s2};
    wire [BSR_LEN-1:0]         bsr_cap;
    wire                       single = (instr == `JTG_OP_SINGLE_CHAIN);
    wire                       drive_now = shift_state(state);
    wire                       cell_en   = cell_clock_state(state);

    assign instr_out = instr;

    genvar i;
    generate
        for (i = 0; i < BSR_LEN; i = i + 1) begin : g_cap
            if (i < `JTG_ID_LEN) begin : g_id
                assign bsr_cap[i] = single ? ID_CODE[i] : smp[i];
            end else begin : g_pad
                assign bsr_cap[i] = single ? 1'b0 : smp[i];
            end
        end
    endgenerate

    // Instruction stages: fixed pattern on capture, one stage per shift.
    always @(posedge ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_shift <= `JTG_IR_CAPTURE;
        end else if (tck_rise) begin
            case (state)
                ST_CAP_IR: ir_shift <= `JTG_IR_CAPTURE;
                ST_SH_IR:  ir_shift <= {tdi_s2, ir_shift[`JTG_IR_LEN-1:1]};
                default:   ir_shift <= ir_shift;
            endcase
        end
    end

    // Bypass stage gives one bit of delay while the bypass path is selected.
    always @(posedge ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            bypass_reg <= `JTG_BYPASS_CAPTURE;
        end else if (tck_rise && sel == `JTG_SEL_BYPASS) begin
            case (state)
                ST_CAP_DR: bypass_reg <= `JTG_BYPASS_CAPTURE;
                ST_SH_DR:  bypass_reg <= tdi_s2;
                default:   bypass_reg <= bypass_reg;
            endcase
        end
    end

    // Identification register reloads on capture and shifts out low bit first.
    always @(posedge ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            id_reg <= ID_CODE;
        end else if (tck_rise && sel == `JTG_SEL_ID) begin
            case (state)
                ST_CAP_DR: id_reg <= ID_CODE;
                ST_SH_DR:  id_reg <= {tdi_s2, id_reg[`JTG_ID_LEN-1:1]};
                default:   id_reg <= id_reg;
            endcase
        end
    end

    // Chain stages sit in series with the pins; idle and pause states hold them.
    always @(posedge ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            bsr <= {BSR_LEN{1'b0}};
        end else if (tck_rise && sel == `JTG_SEL_BSR) begin
            case (state)
                ST_CAP_DR: bsr <= bsr_cap;
                ST_SH_DR:  bsr <= {tdi_s2, bsr[BSR_LEN-1:1]};
                default:   bsr <= bsr;
            endcase
        end
    end

    always @(posedge ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            instr <= `JTG_INSTR_RESET;
        end else if (state == ST_TLR) begin
            instr <= `JTG_INSTR_RESET;
        end else if (tck_fall && state == ST_UP_IR) begin
            instr <= ir_shift;
        end
    end

    // Update latches take the output half of the chain on the test clock fall.
    always @(posedge ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            upd_out <= {N_OUT{1'b0}};
        end else if (tck_fall && state == ST_UP_DR && sel == `JTG_SEL_BSR) begin
            upd_out <= bsr[BSR_LEN-1:N_IN];
        end
    end

    reg                        next_tdo;

    always @* begin
        case (sel)
            `JTG_SEL_BSR: next_tdo = bsr[0];
            `JTG_SEL_ID:  next_tdo = id_reg[0];
            default:      next_tdo = bypass_reg;
        endcase
        if (state == ST_SH_IR) begin
            next_tdo = ir_shift[0];
        end
    end

    always @(posedge ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tdo    <= `JTG_TDO_RESET;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            // The output only moves while driven, so releasing it leaves no stray edge.
            tdo_oe <= drive_now;
            if (drive_now) begin
                tdo <= next_tdo;
            end
        end
    end

    always @(posedge ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            pin_out <= {N_OUT{1'b0}};
        end else begin
            pin_out <= (instr == `JTG_OP_EXTEST) ? upd_out : core_out;
        end
    end

    // The cell clock is a copy of the test clock gated to capture and shift.
    always @(posedge ref_clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            cell_shift_clock <= 1'b0;
        end else begin
            cell_shift_clock <= tck_s2 & cell_en;
        end
    end

endmodule

// *** hw/jtg_defines.vh ***
// Constants of the boundary-scan test access port.
`ifndef JTG_DEFINES_VH
`define JTG_DEFINES_VH

`define JTG_IR_LEN           3
`define JTG_ID_LEN           32

`define JTG_OP_EXTEST        3'h0
`define JTG_OP_SAMPLE        3'h1
`define JTG_OP_IDCODE        3'h2
`define JTG_OP_SINGLE_CHAIN  3'h3
`define JTG_OP_BYPASS        3'h7

`define JTG_IR_CAPTURE       3'h1
`define JTG_INSTR_RESET      3'h2
`define JTG_BYPASS_CAPTURE   1'h0
`define JTG_TDO_RESET        1'h0

`define JTG_SEL_BYPASS       2'h0
`define JTG_SEL_ID           2'h1
`define JTG_SEL_BSR          2'h2

`endif

// *** bench/jtg_tap_monitor.sv ***
// Port checks for the boundary-scan test access port.
`timescale 1ns/1ps
`include "jtg_defines.vh"
module jtg_tap_monitor #(
    parameter N_OUT = 16
) (
    input wire                   ref_clk,
    input wire                   rstn,
    input wire                   tck,
    input wire                   test_reset_n,
    input wire                   tdo,
    input wire                   tdo_oe,
    input wire [N_OUT-1:0]       core_out,
    input wire [N_OUT-1:0]       pin_out,
    input wire                   cell_shift_clock,
    input wire [`JTG_IR_LEN-1:0] instr_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_tck_rise;
        !tck ##1 tck;
    endsequence
    sequence s_tdo_quiet;
        $stable(tdo)[*4];
    endsequence
    property p_release;
        $rose(rstn) |-> instr_out == `JTG_OP_IDCODE && !tdo_oe && pin_out == 0;
    endproperty
    property p_test_reset;
        !test_reset_n |=> instr_out == `JTG_OP_IDCODE && !tdo_oe;
    endproperty
    property p_drive;
        $changed(tdo) && test_reset_n |-> tdo_oe;
    endproperty
    property p_quiet;
        s_tck_rise |-> ##2 s_tdo_quiet;
    endproperty
    property p_oe_edge;
        $changed(tdo_oe) && test_reset_n |-> !$past(tck, 2);
    endproperty
    property p_instr_fall;
        $changed(instr_out) && instr_out != `JTG_OP_IDCODE |-> !$past(tck, 2);
    endproperty
    property p_pins;
        $past(rstn, 3) && $past(test_reset_n, 3) && test_reset_n && instr_out != `JTG_OP_EXTEST
            && $past(instr_out) != `JTG_OP_EXTEST |-> pin_out == $past(core_out);
    endproperty
    property p_cell_clk;
        $rose(cell_shift_clock) |-> $past(tck, 3) || $past(tck, 4);
    endproperty
    a_release:    assert property (p_release) else $error("bad state after reset");
    a_test_reset: assert property (p_test_reset) else $error("test reset ignored");
    a_drive:      assert property (p_drive) else $error("serial out moved undriven");
    a_quiet:      assert property (p_quiet) else $error("serial out moved on rise");
    a_oe_edge:    assert property (p_oe_edge) else $error("enable moved off fall");
    a_instr_fall: assert property (p_instr_fall) else $error("instr moved off fall");
    a_pins:       assert property (p_pins) else $error("pins disturbed");
    a_cell_clk:   assert property (p_cell_clk) else $error("cell clock without tck");
endmodule

bind jtg_tap jtg_tap_monitor #(.N_OUT(N_OUT)) mon (.ref_clk(ref_clk), .rstn(rstn), .tck(tck),
    .test_reset_n(test_reset_n), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out),
    .pin_out(pin_out), .cell_shift_clock(cell_shift_clock), .instr_out(instr_out));

// *** bench/jtg_tester.sv ***
// Model of the external tester that drives the test access port.
`timescale 1ns/1ps
module jtg_tester (
    output reg  tck,
    output reg  tms,
    output reg  tdi,
    input  wire tdo,
    input  wire tdo_oe
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // Inputs change at the fall and stay put for a whole period around the rise.
    task step(input m, input d, output q);
        begin
            tms = m;
            tdi = d;
            #80 tck = 1'b1;
            #78 q = tdo_oe ? tdo : 1'bx;
            #2 tck = 1'b0;
        end
    endtask
    // Steps the controller with a list of mode bits, least significant first.
    task walk(input [7:0] m, input integer k);
        integer i;
        reg     q;
        begin
            for (i = 0; i < k; i = i + 1) begin
                step(m[i], ~tdi, q);
            end
        end
    endtask
    // Full scan from run-test-idle back to it, with an optional pause before bit p.
    task scan(input ir, input integer n, input [31:0] din, input integer p, output [31:0] dout);
        integer i;
        reg     q;
        begin
            dout = 32'h0;
            walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
            for (i = 0; i < n; i = i + 1) begin
                if (p != 0 && i == p) begin
                    walk(8'h04, 4);
                end
                step(i == n - 1 || (p != 0 && i == p - 1), din[i], q);
                dout[i] = q;
            end
            walk(8'h01, 2);
            #160;
        end
    endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the boundary-scan test access port.
`timescale 1ns/1ps
`include "jtg_defines.vh"
module testbench;
    localparam [31:0] ID = 32'hA5C3_0F01; // Arbitrary identification value.
    reg         ref_clk = 1'b0;
    reg         rstn = 1'b0;
    reg         test_reset_n = 1'b1;
    reg  [15:0] pin_in = 16'h0000;
    reg  [15:0] core_out = 16'h9E21;
    wire        tck, tms, tdi, tdo, tdo_oe, cell_shift_clock;
    wire [15:0] pin_out;
    wire [2:0]  instr_out;
    integer     n_errors = 0;
    integer     checks = 0;
    integer     cyc = 0;
    integer     k;
    reg  [31:0] d;
    jtg_tap #(.N_IN(16), .N_OUT(16), .ID_CODE(ID)) dut (.ref_clk(ref_clk), .rstn(rstn),
        .tck(tck), .tms(tms), .tdi(tdi), .test_reset_n(test_reset_n), .tdo(tdo),
        .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out),
        .cell_shift_clock(cell_shift_clock), .instr_out(instr_out));
    jtg_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    always #10 ref_clk = ~ref_clk;
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task finish_test;
        begin
            $display("errors %0d checks %0d", n_errors, checks);
            if (n_errors == 0 && checks > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask
    task ld(input [2:0] op);
        begin
            tester.scan(1'b1, 3, {29'h0, op}, 0, d);
            chk(d[2:0], `JTG_IR_CAPTURE);
            chk(instr_out, op);
        end
    endtask
    task t_idcode;
        begin
            tester.scan(1'b0, 32, 32'h0, 16, d);
            chk(d, ID);
        end
    endtask
    task t_bypass;
        begin
            for (k = 4; k < 8; k = k + 1) begin
                ld(k[2:0]);
                tester.scan(1'b0, 8, 32'hB4, 0, d);
                chk(d[7:0], 8'h68);
            end
        end
    endtask
    task t_chain;
        begin
            @(posedge ref_clk);
            #1 pin_in = 16'h3C5A;
            ld(`JTG_OP_SAMPLE);
            tester.scan(1'b0, 32, 32'h5AA5_0000, 0, d);
            chk(d, 32'h9E21_3C5A);
            chk(pin_out, 16'h9E21);
            ld(`JTG_OP_EXTEST);
            chk(pin_out, 16'h5AA5);
            tester.scan(1'b0, 32, 32'hC3A5_0000, 0, d);
            chk(d, 32'h5AA5_3C5A);
            chk(pin_out, 16'hC3A5);
            ld(`JTG_OP_SINGLE_CHAIN);
            tester.scan(1'b0, 32, 32'h0, 0, d);
            chk(d, ID);
        end
    endtask
    task t_tms5;
        begin
            ld(`JTG_OP_EXTEST);
            tester.walk(8'h01, 3);
            @(posedge ref_clk);
            #1 core_out = 16'h1234;
            tester.walk(8'h1F, 6);
            #100;
            chk(instr_out, `JTG_OP_IDCODE);
            chk(pin_out, 16'h1234);
        end
    endtask
    task t_trst;
        begin
            ld(`JTG_OP_BYPASS);
            @(posedge ref_clk);
            #1 test_reset_n = 1'b0;
            repeat (3) @(posedge ref_clk);
            chk(instr_out, `JTG_OP_IDCODE);
            chk(tdo_oe, 1'b0);
            #1 test_reset_n = 1'b1;
            repeat (6) @(posedge ref_clk);
            #1;
            tester.walk(8'h00, 1);
            t_idcode;
        end
    endtask
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            finish_test;
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        #1 rstn = 1'b1;
        repeat (6) @(posedge ref_clk);
        chk(instr_out, `JTG_OP_IDCODE);
        chk(tdo_oe, 1'b0);
        #1;
        tester.walk(8'h00, 1);
        t_idcode;
        t_bypass;
        t_chain;
        t_tms5;
        t_trst;
        finish_test;
    end
endmodule
